// ### i2c_txarb_cfg.svh
`ifndef I2C_TXARB_CFG_SVH
`define I2C_TXARB_CFG_SVH

// ****************************************************************
// Register indexes
// ****************************************************************
`define REG_CONTROL      4'h0
`define REG_STATUS       4'h1
`define REG_DATA         4'h2
`define REG_EXT_CTRL     4'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define CTL_IF_ENABLE    0
`define CTL_ACK_CHECK    1
`define CTL_TX_SELECT    2
`define CTL_SERIAL_FMT   3
`define CTL_START_CMD    4
`define CTL_STOP_CMD     5
`define STS_IRQ_FLAG     0
`define STS_ARB_LOST     1
`define EXT_REQ_FLAG     4
`define EXT_ARB_IRQ_EN   3
`define EXT_ARB_COND     2

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define CONTROL_RESET    8'h00
`define EXT_RESET        8'h00
`define RESTRICT_KEEP    2'b00
`define RESTRICT_LIFT    2'b11
`define LAST_BIT_I2C     4'h8
`define LAST_BIT_SERIAL  4'h7

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ          50
`define SCL_QTR_NS       2500
`define SCL_QTR_CYC      ((`SCL_QTR_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### i2c_txarb_pkg.sv
package i2c_txarb_pkg;

  // Transmit engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_BIT   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_STOP  = 3'b100
  } tx_state_t;

endpackage

// ### i2c_line_if.sv
`timescale 1ns/10ps
interface i2c_line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic start_det;
  logic stop_det;
  logic bus_busy;

  modport det (output scl_s, sda_s, scl_rise, start_det, stop_det,
               bus_busy);
  modport ctl (input  scl_s, sda_s, scl_rise, start_det, stop_det,
               bus_busy);
endinterface

// ### i2c_sync2.sv
`timescale 1ns/10ps
module i2c_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1;

  // Two flip-flops; lines idle high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= '1;
      q_o    <= '1;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule

// ### i2c_bus_cond_detect.sv
`timescale 1ns/10ps
module i2c_bus_cond_detect (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Synchronised bus lines
  input  wire logic scl_sync_i,
  input  wire logic sda_sync_i,
  // Decoded bus events
  i2c_line_if.det   line
);
  logic scl_prev;
  logic sda_prev;

  // Previous levels and registered events
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_prev       <= 1'b1;
      sda_prev       <= 1'b1;
      line.scl_s     <= 1'b1;
      line.sda_s     <= 1'b1;
      line.scl_rise  <= 1'b0;
      line.start_det <= 1'b0;
      line.stop_det  <= 1'b0;
    end else begin
      scl_prev       <= scl_sync_i;
      sda_prev       <= sda_sync_i;
      line.scl_s     <= scl_sync_i;
      line.sda_s     <= sda_sync_i;
      line.scl_rise  <= scl_sync_i & ~scl_prev;
      line.start_det <= scl_sync_i & scl_prev & sda_prev & ~sda_sync_i;
      line.stop_det  <= scl_sync_i & scl_prev & ~sda_prev & sda_sync_i;
    end
  end

  // Bus busy between start and stop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      line.bus_busy <= 1'b0;
    end else if (line.start_det) begin
      line.bus_busy <= 1'b1;
    end else if (line.stop_det) begin
      line.bus_busy <= 1'b0;
    end
  end
endmodule

// ### i2c_tx_request_arbitration_ctrl.sv
// Summary of operation
// - Start condition on bus sets request flag
// - Holding-to-shift transfer sets request flag
// - Byte done, flag low: set at 9th rise, 8th in serial format
// - Late buffer write clears briefly, reload sets again
// - Data register write clears request flag
// - Stop condition on bus clears request flag
// - Writing interface enable 0 clears flag
// - Acknowledge 1 with checking on: no set
// - Flag read-only, resets 0, 1 means writable
// - Arbitration loss sets interrupt flag when enabled
// - Select 0: SDA mismatch or SCL pulled low
// - Select 1: SDA mismatch or SDA pulled low
// - Restriction field 00 keeps, 11 lifts; 01/10 barred
`timescale 1ns/10ps
`include "i2c_txarb_cfg.svh"
module i2c_tx_request_arbitration_ctrl #(
  parameter int QTR_CYCLES = `SCL_QTR_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // Two-wire bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Status outputs
  output logic            irq_request_o,
  output logic            restrictions_lifted_o
);
  import i2c_txarb_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  i2c_line_if             line ();
  logic      [1:0]        pins_sync;
  logic                   if_enable;
  logic                   ack_check_enable;
  logic                   transmit_receive_select;
  logic                   serial_fmt;
  logic                   arb_lost_irq_enable;
  logic                   arb_lost_condition_select;
  logic      [1:0]        restriction_cancel;
  logic                   tx_write_request_flag;
  logic                   interface_interrupt_flag;
  logic                   arb_lost;
  logic                   ack_received;
  logic      [7:0]        tx_holding_buffer;
  logic                   hold_full;
  logic      [7:0]        shift_register;
  tx_state_t              state;
  logic      [1:0]        phase;
  logic      [3:0]        bit_cnt;
  logic                   scl_low;
  logic                   sda_low;
  logic                   start_pending;
  logic                   stop_req;
  logic      [15:0]       qtr_cnt;
  logic                   tick;
  logic                   wr_control;
  logic                   wr_status;
  logic                   wr_data;
  logic                   wr_ext;
  logic                   if_disable_wr;
  logic                   load_pulse;
  logic                   last_rise;
  logic                   ack_fail;
  logic                   done_set;
  logic                   mismatch;
  logic                   scl_stolen;
  logic                   sda_stolen;
  logic                   lose_now;
  logic      [3:0]        last_bit;

  // ****************************************************************
  // Pin sampling and bus events
  // ****************************************************************

  // Two-flop synchroniser for both lines
  i2c_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({scl_i, sda_i}),
    .q_o     (pins_sync)
  );

  // Start, stop, rising SCL and busy detection
  i2c_bus_cond_detect u_detect (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .scl_sync_i (pins_sync[1]),
    .sda_sync_i (pins_sync[0]),
    .line       (line)
  );

  // Open-drain drive: enable high while pulling low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_low;
  assign sda_oe_o = sda_low;

  // ****************************************************************
  // Register writes
  // ****************************************************************

  // Write strobes per register
  assign wr_control    = reg_write_i && (reg_addr_i == `REG_CONTROL);
  assign wr_status     = reg_write_i && (reg_addr_i == `REG_STATUS);
  assign wr_data       = reg_write_i && (reg_addr_i == `REG_DATA);
  assign wr_ext        = reg_write_i && (reg_addr_i == `REG_EXT_CTRL);
  assign if_disable_wr = wr_control && !reg_wdata_i[`CTL_IF_ENABLE];

  // Control register fields
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      if_enable               <= 1'b0;
      ack_check_enable        <= 1'b0;
      transmit_receive_select <= 1'b0;
      serial_fmt              <= 1'b0;
    end else if (wr_control) begin
      if_enable               <= reg_wdata_i[`CTL_IF_ENABLE];
      ack_check_enable        <= reg_wdata_i[`CTL_ACK_CHECK];
      transmit_receive_select <= reg_wdata_i[`CTL_TX_SELECT];
      serial_fmt              <= reg_wdata_i[`CTL_SERIAL_FMT];
    end
  end

  // Extended control fields; barred restriction codes are ignored
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arb_lost_irq_enable       <= 1'b0;
      arb_lost_condition_select <= 1'b0;
      restriction_cancel        <= `RESTRICT_KEEP;
    end else if (wr_ext) begin
      arb_lost_irq_enable       <= reg_wdata_i[`EXT_ARB_IRQ_EN];
      arb_lost_condition_select <= reg_wdata_i[`EXT_ARB_COND];
      if (reg_wdata_i[1:0] == `RESTRICT_KEEP ||
          reg_wdata_i[1:0] == `RESTRICT_LIFT) begin
        restriction_cancel <= reg_wdata_i[1:0];
      end
    end
  end

  assign restrictions_lifted_o = (restriction_cancel == `RESTRICT_LIFT);

  // Transmit holding buffer; a write takes priority over a load
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_holding_buffer <= 8'h00;
      hold_full         <= 1'b0;
    end else if (if_disable_wr) begin
      hold_full <= 1'b0;
    end else if (wr_data) begin
      tx_holding_buffer <= reg_wdata_i;
      hold_full         <= 1'b1;
    end else if (load_pulse) begin
      hold_full <= 1'b0;
    end
  end

  // Start and stop commands wait for the engine
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_pending <= 1'b0;
      stop_req      <= 1'b0;
    end else if (if_disable_wr || lose_now) begin
      start_pending <= 1'b0;
      stop_req      <= 1'b0;
    end else begin
      if (wr_control && reg_wdata_i[`CTL_START_CMD]) begin
        start_pending <= 1'b1;
      end else if (state == ST_START) begin
        start_pending <= 1'b0;
      end
      if (wr_control && reg_wdata_i[`CTL_STOP_CMD]) begin
        stop_req <= 1'b1;
      end else if (state == ST_STOP) begin
        stop_req <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // SCL quarter-period divider
  // ****************************************************************

  // One-cycle tick every quarter SCL period while enabled
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      qtr_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (!if_enable || qtr_cnt == 16'(QTR_CYCLES - 1)) begin
      qtr_cnt <= 16'h0000;
      tick    <= if_enable;
    end else begin
      qtr_cnt <= qtr_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // ****************************************************************
  // Byte completion and arbitration checks
  // ****************************************************************

  // Last clock of a byte: 9th in I2C format, 8th in serial format
  assign last_bit  = serial_fmt ? `LAST_BIT_SERIAL : `LAST_BIT_I2C;
  assign last_rise = line.scl_rise && (state == ST_BIT) &&
                     (bit_cnt == last_bit);
  assign ack_fail  = !serial_fmt && ack_check_enable && line.sda_s;
  assign done_set  = last_rise && !tx_write_request_flag &&
                     !ack_fail;

  // Data bit seen low while we released it at SCL rise
  assign mismatch   = line.scl_rise && (state == ST_BIT) &&
                      (bit_cnt < `LAST_BIT_I2C) && !sda_low &&
                      !line.sda_s;
  // SCL low while released and already seen high
  assign scl_stolen = !arb_lost_condition_select && !scl_low &&
                      !line.scl_s && (phase == 2'd3) &&
                      (state == ST_BIT);
  // SDA pulled low while idle or with a start waiting
  assign sda_stolen = arb_lost_condition_select && !sda_low &&
                      !line.sda_s && ((state == ST_IDLE &&
                      !line.bus_busy) || start_pending);
  assign lose_now   = if_enable && (mismatch || scl_stolen ||
                      sda_stolen);

  // Acknowledge bit captured at the last rise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_received <= 1'b0;
    end else if (last_rise && !serial_fmt) begin
      ack_received <= line.sda_s;
    end
  end

  // ****************************************************************
  // Transmit engine
  // ****************************************************************

  // Master transmit sequencer, four ticks per bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state          <= ST_IDLE;
      phase          <= 2'd0;
      bit_cnt        <= 4'h0;
      shift_register <= 8'h00;
      scl_low        <= 1'b0;
      sda_low        <= 1'b0;
      load_pulse     <= 1'b0;
    end else if (!if_enable || lose_now) begin
      state      <= ST_IDLE;
      phase      <= 2'd0;
      scl_low    <= 1'b0;
      sda_low    <= 1'b0;
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_pending && !line.bus_busy &&
              transmit_receive_select && tick) begin
            state <= ST_START;
            phase <= 2'd0;
          end
        end
        ST_START: begin
          if (tick) begin
            if (phase == 2'd0) begin
              sda_low <= 1'b1;
              phase   <= 2'd1;
            end else begin
              scl_low <= 1'b1;
              state   <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // SCL held low until a byte or a stop is available
          if (hold_full && !load_pulse) begin
            shift_register <= tx_holding_buffer;
            load_pulse     <= 1'b1;
            bit_cnt        <= 4'h0;
            phase          <= 2'd0;
            state          <= ST_BIT;
          end else if (stop_req && tick) begin
            phase <= 2'd0;
            state <= ST_STOP;
          end
        end
        ST_BIT: begin
          if (tick) begin
            case (phase)
              2'd0: begin
                sda_low <= (bit_cnt < `LAST_BIT_I2C) ?
                           !shift_register[7] : 1'b0;
                phase   <= 2'd1;
              end
              2'd1: begin
                scl_low <= 1'b0;
                phase   <= 2'd2;
              end
              2'd2: begin
                if (line.scl_s) begin
                  phase <= 2'd3;
                end
              end
              default: begin
                scl_low        <= 1'b1;
                shift_register <= {shift_register[6:0], 1'b0};
                bit_cnt        <= bit_cnt + 4'h1;
                phase          <= 2'd0;
                if (bit_cnt == last_bit) begin
                  state <= ST_WAIT;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            case (phase)
              2'd0: begin
                sda_low <= 1'b1;
                phase   <= 2'd1;
              end
              2'd1: begin
                scl_low <= 1'b0;
                phase   <= 2'd2;
              end
              default: begin
                sda_low <= 1'b0;
                state   <= ST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************

  // Transmit write-request flag; sets beat the data-write clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_write_request_flag <= 1'b0;
    end else if (if_disable_wr) begin
      tx_write_request_flag <= 1'b0;
    end else if (line.start_det || load_pulse || done_set) begin
      tx_write_request_flag <= 1'b1;
    end else if (line.stop_det) begin
      tx_write_request_flag <= 1'b0;
    end else if (wr_data) begin
      tx_write_request_flag <= 1'b0;
    end
  end

  // Arbitration-lost status and interrupt flag; set beats clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arb_lost                 <= 1'b0;
      interface_interrupt_flag <= 1'b0;
    end else begin
      if (lose_now) begin
        arb_lost <= 1'b1;
      end else if (wr_status && !reg_wdata_i[`STS_ARB_LOST]) begin
        arb_lost <= 1'b0;
      end
      if (lose_now && arb_lost_irq_enable) begin
        interface_interrupt_flag <= 1'b1;
      end else if (wr_status && !reg_wdata_i[`STS_IRQ_FLAG]) begin
        interface_interrupt_flag <= 1'b0;
      end
    end
  end

  assign irq_request_o = interface_interrupt_flag;

  // ****************************************************************
  // Register reads
  // ****************************************************************

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_read_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == `REG_CONTROL) begin
      reg_rdata_o <= {4'h0, serial_fmt, transmit_receive_select,
                      ack_check_enable, if_enable};
    end else if (reg_addr_i == `REG_STATUS) begin
      reg_rdata_o <= {3'h0, hold_full, ack_received, line.bus_busy,
                      arb_lost, interface_interrupt_flag};
    end else if (reg_addr_i == `REG_DATA) begin
      reg_rdata_o <= tx_holding_buffer;
    end else if (reg_addr_i == `REG_EXT_CTRL) begin
      reg_rdata_o <= {3'h0, tx_write_request_flag, arb_lost_irq_enable,
                      arb_lost_condition_select, restriction_cancel};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule

// ### i2c_txarb_checker_props.sv
`timescale 1ns/10ps
`include "i2c_txarb_cfg.svh"
module i2c_txarb_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // Bus drive and status
  input wire logic       scl_oe_o,
  input wire logic       sda_oe_o,
  input wire logic       irq_request_o,
  input wire logic       restrictions_lifted_o
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic ext_wr;
  logic ext_rd;
  logic ctl_off;
  logic arb_en;
  logic arb_sel;

  // Decoded accesses
  assign ext_wr  = reg_write_i && (reg_addr_i == `REG_EXT_CTRL);
  assign ext_rd  = reg_read_i && (reg_addr_i == `REG_EXT_CTRL);
  assign ctl_off = reg_write_i && (reg_addr_i == `REG_CONTROL) &&
                   !reg_wdata_i[`CTL_IF_ENABLE];

  // Shadow of the arbitration enable and select bits
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arb_en  <= 1'b0;
      arb_sel <= 1'b0;
    end else if (ext_wr) begin
      arb_en  <= reg_wdata_i[`EXT_ARB_IRQ_EN];
      arb_sel <= reg_wdata_i[`EXT_ARB_COND];
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_rdata_idle_zero: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  a_ext_top_zero: assert property (
    ext_rd |=> reg_rdata_o[7:5] == 3'b000)
    else $error("unused extended bits read non-zero");
  a_restrict_lift: assert property (
    $rose(restrictions_lifted_o) |->
      $past(ext_wr && reg_wdata_i[1:0] == 2'b11))
    else $error("restrictions lifted without code 11");
  a_restrict_barred: assert property (
    ext_wr && (reg_wdata_i[1:0] inside {2'b01, 2'b10}) |=>
      $stable(restrictions_lifted_o))
    else $error("barred restriction code changed state");
  a_restrict_read: assert property (
    ext_rd |=> reg_rdata_o[1:0] == {2{restrictions_lifted_o}})
    else $error("restriction field readback wrong");
  a_arb_readback: assert property (
    ext_rd |=> reg_rdata_o[3:2] == {arb_en, arb_sel})
    else $error("arbitration bits readback wrong");
  a_irq_masked: assert property (
    !arb_en && !irq_request_o |=> !irq_request_o)
    else $error("interrupt raised while disabled");
  a_arb_release: assert property (
    $rose(irq_request_o) |-> ##[0:2] (!scl_oe_o && !sda_oe_o))
    else $error("lines held after arbitration loss");
  a_disable_release: assert property (
    ctl_off |-> ##[1:4] (!scl_oe_o && !sda_oe_o))
    else $error("lines held after interface disable");

  // Main scenarios reached
  c_irq_raised: cover property ($rose(irq_request_o));
  c_lifted: cover property ($rose(restrictions_lifted_o));
  c_flag_seen: cover property ($past(ext_rd) && reg_rdata_o[4]);
endmodule

bind i2c_tx_request_arbitration_ctrl i2c_txarb_checker chk_u (
  .clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
  .reg_read_i, .reg_rdata_o, .scl_oe_o, .sda_oe_o, .irq_request_o,
  .restrictions_lifted_o);

// ### i2c_slave_model.sv
`timescale 1ns/10ps
module i2c_slave_model (
  // Bus lines as seen on the wire
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Test controls
  input  wire logic ack_en_i,
  input  wire logic grab_i,
  // Open-drain pull on SDA
  output logic      sda_oe_o
);
  int   bit_cnt;
  logic in_frame;
  logic ack_drv;

  // Idle at time zero
  initial begin
    in_frame = 1'b0;
    bit_cnt  = 0;
    ack_drv  = 1'b0;
  end

  // Start condition opens a frame
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      in_frame = 1'b1;
      bit_cnt  = -1;
    end
  end

  // Stop condition closes it and drops any acknowledge
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      in_frame = 1'b0;
      ack_drv  = 1'b0;
    end
  end

  // Count bits; pull SDA low through the ninth clock
  always @(negedge scl_i) begin
    if (in_frame) begin
      bit_cnt = (bit_cnt >= 9) ? 1 : bit_cnt + 1;
      ack_drv = ack_en_i && (bit_cnt == 8);
    end
  end

  assign sda_oe_o = ack_drv | grab_i;
endmodule

// ### tb.sv
`timescale 1ns/10ps
`include "i2c_txarb_cfg.svh"
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clk_i;
  logic       reset_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_write_i;
  logic       reg_read_i;
  logic [7:0] reg_rdata_o;
  logic       scl_i;
  logic       sda_i;
  logic       scl_oe_o;
  logic       sda_oe_o;
  logic       irq_request_o;
  logic       restrictions_lifted_o;
  logic       slv_oe;
  logic       grab;
  int         miscompares;
  int         n_tests;
  logic [7:0] seq_w [6] = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h03};
  logic [7:0] seq_e [6] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03};

  // Wired-AND bus with pull-ups
  assign scl_i = ~scl_oe_o;
  assign sda_i = ~(sda_oe_o | slv_oe);

  i2c_tx_request_arbitration_ctrl #(.QTR_CYCLES(4)) dut_u (
    .clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .scl_i, .scl_o(), .scl_oe_o, .sda_i,
    .sda_o(), .sda_oe_o, .irq_request_o, .restrictions_lifted_o);

  i2c_slave_model slv_u (.scl_i(scl_i), .sda_i(sda_i),
    .ack_en_i(1'b1), .grab_i(grab), .sda_oe_o(slv_oe));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic chk(input string n, input logic [7:0] e, s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, e, v & m);
  endtask

  task automatic poll_flag(input logic e);
    logic [7:0] v;
    int         i;
    for (i = 0; i < 3000; i++) begin
      rd(`REG_EXT_CTRL, v);
      if (v[4] === e) break;
    end
    chk("request flag", {7'h0, e}, {7'h0, v[4]});
    if (i == 3000) tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    grab = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // Extended register reset, read-only flag, restriction codes
    rchk("ext reset", `REG_EXT_CTRL, 8'hFF, 8'h00);
    wr(`REG_EXT_CTRL, 8'hFF);
    rchk("ext ro", `REG_EXT_CTRL, 8'hFF, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      wr(`REG_EXT_CTRL, seq_w[i]);
      rchk("restrict", `REG_EXT_CTRL, 8'hFF, seq_e[i]);
    end
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    // Transfer: start, reload, clear by write, stop
    wr(`REG_CONTROL, 8'h17);
    poll_flag(1'b1);
    wr(`REG_DATA, 8'hA5);
    poll_flag(1'b1);
    wr(`REG_DATA, 8'h3C);
    rchk("flag on write", `REG_EXT_CTRL, 8'h10, 8'h00);
    poll_flag(1'b1);
    wr(`REG_CONTROL, 8'h27);
    poll_flag(1'b0);
    // Serial-format start sets the flag, disable clears it
    wr(`REG_CONTROL, 8'h1F);
    poll_flag(1'b1);
    wr(`REG_CONTROL, 8'h00);
    rchk("flag on off", `REG_EXT_CTRL, 8'h10, 8'h00);
    // SDA held low: select 1 enabled, select 1 masked, select 0
    for (int k = 0; k < 3; k++) begin
      wr(`REG_EXT_CTRL, (k == 0) ? 8'h0C : ((k == 1) ? 8'h04 : 8'h08));
      @(posedge clk_i);
      grab <= 1'b1;
      repeat (10) @(posedge clk_i);
      wr(`REG_CONTROL, 8'h15);
      repeat (20) @(posedge clk_i);
      chk("irq", {7'h0, k == 0}, {7'h0, irq_request_o});
      rchk("arb lost", `REG_STATUS, 8'h02,
           (k < 2) ? 8'h02 : 8'h00);
      @(posedge clk_i);
      grab <= 1'b0;
      repeat (10) @(posedge clk_i);
      wr(`REG_STATUS, 8'h00);
      rchk("irq clear", `REG_STATUS, 8'h03, 8'h00);
    end
    wr(`REG_CONTROL, 8'h00);
    tally_and_finish();
  end
endmodule
